// [ascl_loader.v]
// Active serial configuration loader: masters the serial flash link,
// tracks the shared status and done lines, and runs initialization.
// Assumes straps and pins are asynchronous; open-drain lines are pulled up outside.
`timescale 1ns/1ps
`include "ascl_defs.vh"
module ascl_loader #(
  parameter POR_CYCLES = `ASCL_POR_MS * 1000 * `ASCL_CLK_MHZ,
  parameter OWN_BITS = `ASCL_OWN_BITS,
  parameter TOTAL_BITS = `ASCL_TOTAL_BITS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Board straps and host request
  input wire [1:0] schemeSelect,
  input wire chainEnableInN,
  input wire reloadRequestN,
  // Options
  input wire autoRestartEn,
  input wire userStartupClockEn,
  input wire userStartupClock,
  // Open-drain status line
  input wire configStatusNIn,
  output wire configStatusNOut,
  output wire configStatusNOe,
  // Open-drain done line
  input wire loadCompleteIn,
  output wire loadCompleteOut,
  output wire loadCompleteOe,
  // Open-drain init-done pin
  output wire initDoneOut,
  output wire initDoneOe,
  // Flash link
  output wire serialLinkClock,
  output wire flashSelectOutN,
  output wire flashCommandOut,
  input wire serialDataIn,
  // Chain
  output wire chainEnableOutN,
  // User I/O control
  output wire userIoFloat,
  output wire userIoPullupEn,
  output wire userMode,
  // Configuration bytes
  output wire [7:0] configByte,
  output wire configByteValid,
  input wire configByteReady
);

  localparam ST_POR = 4'h0;
  localparam ST_WAIT = 4'h1;
  localparam ST_CMD = 4'h2;
  localparam ST_DATA = 4'h3;
  localparam ST_DONE = 4'h4;
  localparam ST_INIT = 4'h5;
  localparam ST_USER = 4'h6;
  localparam ST_ERR = 4'h7;
  localparam ST_RELOAD = 4'h8;

  reg [3:0] state_q;
  reg [23:0] porCnt_q;
  reg [11:0] errCnt_q;
  reg [1:0] linkPhase_q;
  reg linkClk_q;
  reg csN_q;
  reg [31:0] cmdShift_q;
  reg [5:0] cmdCnt_q;
  reg [23:0] bitCnt_q;
  reg [7:0] byteShift_q;
  reg [2:0] byteCnt_q;
  reg pushValid_q;
  reg [7:0] pushData_q;
  reg [3:0] frameCnt_q;
  reg parity_q;
  reg ownDone_q;
  reg initDoneEn_q;
  reg [3:0] initDiv_q;
  reg [7:0] initCnt_q;
  reg usrClkPrev_q;

  wire [7:0] asyncIn;
  wire [7:0] syncd;
  wire [1:0] sScheme;
  wire sCeInN;
  wire sReloadN;
  wire sStatusN;
  wire sDone;
  wire sData;
  wire sUsrClk;
  wire fifoInReady;
  wire linkActive;
  wire phaseEnd;
  wire linkRise;
  wire linkFall;
  wire intTick;
  wire usrRise;
  wire initTick;
  wire ownBit;
  wire frameBad;
  wire isMaster;

  // Every strap, request, shared-line, flash data and user-clock input passes two flip-flops before any logic reads it
  assign asyncIn = {schemeSelect, chainEnableInN, reloadRequestN, configStatusNIn,
                    loadCompleteIn, serialDataIn, userStartupClock};
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : gSync
      reg meta_q;
      reg stable_q;
      always @(posedge clk)
      begin
        meta_q <= asyncIn[i];
        stable_q <= meta_q;
      end
      assign syncd[i] = stable_q;
    end
  endgenerate

  assign sScheme = syncd[7:6];
  assign sCeInN = syncd[5];
  assign sReloadN = syncd[4];
  assign sStatusN = syncd[3];
  assign sDone = syncd[2];
  assign sData = syncd[1];
  assign sUsrClk = syncd[0];

  // Only the strapped first device masters the flash
  assign isMaster = (sScheme == `ASCL_SCHEME_AS) && !sCeInN;

  // Link clock divider; it pauses while the buffer is full, which the flash tolerates
  assign linkActive = ((state_q == ST_CMD) || (state_q == ST_DATA)) && fifoInReady;
  assign phaseEnd = (linkPhase_q == (`ASCL_LINK_HALF - 1));
  assign linkRise = linkActive && phaseEnd && !linkClk_q;
  assign linkFall = linkActive && phaseEnd && linkClk_q;

  always @(posedge clk)
  begin
    if (!rst_n || !sStatusN || !sReloadN || (linkRise && ownBit && frameBad) ||
        !((state_q == ST_CMD) || (state_q == ST_DATA))) // Abort drops the clock in the same edge as the select
    begin
      linkPhase_q <= 2'h0;
      linkClk_q <= 1'b0;
    end
    else if (linkActive)
    begin
      if (phaseEnd)
      begin
        linkPhase_q <= 2'h0;
        linkClk_q <= ~linkClk_q;
      end
      else
        linkPhase_q <= linkPhase_q + 2'h1;
    end
  end
  // Initialization clock: internal divider or edges of the user clock
  assign intTick = (initDiv_q == (`ASCL_INIT_DIV - 1));
  assign usrRise = sUsrClk && !usrClkPrev_q;
  assign initTick = userStartupClockEn ? usrRise : intTick;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      initDiv_q <= 4'h0;
      usrClkPrev_q <= 1'b0;
    end
    else
    begin
      usrClkPrev_q <= sUsrClk;
      initDiv_q <= intTick ? 4'h0 : initDiv_q + 4'h1;
    end
  end

  // Received bit belongs to this device while below its own length
  assign ownBit = (bitCnt_q < OWN_BITS);
  assign frameBad = (frameCnt_q == (`ASCL_FRAME_BITS - 1)) && (parity_q ^ sData);

  // Main sequencer
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_POR;
      porCnt_q <= 24'h000000;
      errCnt_q <= 12'h000;
      csN_q <= 1'b1;
      cmdShift_q <= 32'h00000000;
      cmdCnt_q <= 6'h00;
      bitCnt_q <= 24'h000000;
      ownDone_q <= 1'b0;
      initDoneEn_q <= 1'b0;
      initCnt_q <= 8'h00;
    end
    else if (!sReloadN && (state_q != ST_POR) && (state_q != ST_RELOAD))
    begin
      // Reload request wins from any state after power-on
      state_q <= ST_RELOAD;
      csN_q <= 1'b1;
      ownDone_q <= 1'b0;
      initDoneEn_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_POR:
        begin
          if (porCnt_q == POR_CYCLES[23:0] - 24'h1)
            state_q <= ST_WAIT;
          else
            porCnt_q <= porCnt_q + 24'h1;
        end
        ST_WAIT:
        begin
          // Status released; start only once the shared line reads high
          if (sStatusN && isMaster)
          begin
            state_q <= ST_CMD;
            csN_q <= 1'b0;
            cmdShift_q <= {`ASCL_READ_CMD, `ASCL_START_ADDR};
            cmdCnt_q <= 6'h00;
            bitCnt_q <= 24'h000000;
            ownDone_q <= 1'b0;
            initDoneEn_q <= 1'b0;
          end
        end
        ST_CMD:
        begin
          if (!sStatusN)
          begin
            state_q <= ST_ERR;
            csN_q <= 1'b1;
            errCnt_q <= 12'h000;
          end
          else if (linkRise)
            cmdCnt_q <= cmdCnt_q + 6'h1;
          else if (linkFall)
          begin
            // Command shifts on the falling edge; data follows the last one
            cmdShift_q <= {cmdShift_q[30:0], 1'b0};
            if (cmdCnt_q == `ASCL_CMD_BITS)
              state_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (!sStatusN || (linkRise && ownBit && frameBad))
          begin
            state_q <= ST_ERR;
            csN_q <= 1'b1;
            errCnt_q <= 12'h000;
            ownDone_q <= 1'b0;
          end
          else if (linkRise)
          begin
            // Sample on the rising edge; option bit is first of first frame
            bitCnt_q <= bitCnt_q + 24'h1;
            if (bitCnt_q == 24'h000000)
              initDoneEn_q <= sData;
            if (bitCnt_q == OWN_BITS[23:0] - 24'h1)
              ownDone_q <= 1'b1;
          end
          else if (linkFall && (bitCnt_q == TOTAL_BITS[23:0]))
          begin
            // Whole chain stream read in one burst, then deselect
            csN_q <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          if (!sStatusN)
          begin
            state_q <= ST_ERR;
            errCnt_q <= 12'h000;
            ownDone_q <= 1'b0;
          end
          else if (sDone)
          begin
            state_q <= ST_INIT;
            initCnt_q <= 8'h00;
          end
        end
        ST_INIT:
        begin
          if (initTick)
          begin
            if (initCnt_q == `ASCL_INIT_CLKS - 1)
              state_q <= ST_USER;
            else
              initCnt_q <= initCnt_q + 8'h01;
          end
        end
        ST_USER:
        begin
          state_q <= ST_USER;
        end
        ST_ERR:
        begin
          // Select stays high through the timeout, giving the flash its reset pulse
          if (errCnt_q != `ASCL_RESTART_CYC - 1)
            errCnt_q <= errCnt_q + 12'h001;
          else if (autoRestartEn)
            state_q <= ST_WAIT;
        end
        ST_RELOAD:
        begin
          if (sReloadN)
            state_q <= ST_WAIT;
        end
        default:
        begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // Byte assembly and frame parity over this device's own bits
  always @(posedge clk)
  begin
    if (!rst_n || (state_q != ST_DATA))
    begin
      byteShift_q <= 8'h00;
      byteCnt_q <= 3'h0;
      pushValid_q <= 1'b0;
      pushData_q <= 8'h00;
      frameCnt_q <= 4'h0;
      parity_q <= 1'b0;
    end
    else
    begin
      pushValid_q <= 1'b0;
      if (linkRise && ownBit)
      begin
        byteShift_q <= {byteShift_q[6:0], sData};
        byteCnt_q <= byteCnt_q + 3'h1;
        if (byteCnt_q == 3'h7)
        begin
          pushValid_q <= 1'b1;
          pushData_q <= {byteShift_q[6:0], sData};
        end
        frameCnt_q <= frameCnt_q + 4'h1;
        parity_q <= (frameCnt_q == (`ASCL_FRAME_BITS - 1)) ? 1'b0 : (parity_q ^ sData);
      end
    end
  end

  // Buffer between the link and the loader; full stalls the link clock
  ascl_fifo #(
    .WIDTH(`ASCL_BYTE_W),
    .DEPTH(`ASCL_FIFO_DEPTH),
    .AW(2)
  ) uFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushData_q),
    .outValid(configByteValid),
    .outReady(configByteReady),
    .outData(configByte)
  );

  // Open-drain lines only ever pull low
  assign configStatusNOut = 1'b0;
  assign loadCompleteOut = 1'b0;
  assign initDoneOut = 1'b0;
  assign configStatusNOe = (state_q == ST_POR) || (state_q == ST_ERR) || (state_q == ST_RELOAD);
  assign loadCompleteOe = !ownDone_q;
  assign initDoneOe = initDoneEn_q && (state_q != ST_USER);

  // Flash link pins
  assign serialLinkClock = linkClk_q;
  assign flashSelectOutN = csN_q;
  assign flashCommandOut = cmdShift_q[31];
  assign chainEnableOutN = !ownDone_q;

  // User I/O float with pull-ups until user mode
  assign userMode = (state_q == ST_USER);
  assign userIoFloat = !userMode;
  assign userIoPullupEn = !userMode;

endmodule // ascl_loader

// [ascl_defs.vh]
// Constants for the active serial configuration loader.
// Assumes a 100 MHz system clock; included by bare name, definitions only.
// Contract
// - Power-on reset drives status and done low
// - Release status, configure once it reads high
// - User I/O floated with pull-ups until user
// - Link clock from own oscillator, 14-20 MHz
// - Change outputs on fall, sample on rise
// - Select flash low, command out, data in
// - Release done, initialize after it rises
// - Init clock internal 10 MHz or user clock
// - Count 136 init clocks before user mode
// - Init-done low when enabled, released at end
// - User mode removes pull-ups, enables I/O
// - Frame error drives status low, done low
// - Auto restart pulses select, waits 30 us
// - Reload low resets lines, floats I/O
// - Chain enable out low after own data
// - Hold shared done low until own data
// - Any error restarts chain within 40 us; here only with autoRestartEn set, else status held low until reload
`ifndef ASCL_DEFS_VH
`define ASCL_DEFS_VH

// Clock and derived rates
`define ASCL_CLK_MHZ 100
`define ASCL_LINK_MHZ 17
`define ASCL_LINK_HALF ((`ASCL_CLK_MHZ + 2 * `ASCL_LINK_MHZ - 1) / (2 * `ASCL_LINK_MHZ))
`define ASCL_INIT_MHZ 10
`define ASCL_INIT_DIV (`ASCL_CLK_MHZ / `ASCL_INIT_MHZ)

// Timing
`define ASCL_POR_MS 100
`define ASCL_RESTART_US 30
`define ASCL_RESTART_CYC (`ASCL_RESTART_US * `ASCL_CLK_MHZ)
`define ASCL_INIT_CLKS 136

// Link and stream format
`define ASCL_SCHEME_AS 2'h0
`define ASCL_READ_CMD 8'h03
`define ASCL_START_ADDR 24'h000000
`define ASCL_CMD_BITS 32
`define ASCL_FRAME_BITS 16
`define ASCL_OWN_BITS 4096
`define ASCL_TOTAL_BITS 8192

// Data path buffer
`define ASCL_BYTE_W 8
`define ASCL_FIFO_DEPTH 4

`endif

// [ascl_fifo.v]
// Small synchronous FIFO between the bit assembler and the loader output.
// Assumes both sides run on clk; depth is a power of two.
`timescale 1ns/1ps
module ascl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest flags straight from the occupancy count
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem_q[rdPtr_q];

  // Storage write
  always @(posedge clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= inData;
  end

  // Pointers and count
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // ascl_fifo

// [ascl_loader_properties.sv]
// Checker for the configuration loader: pin relations over time.
// Assumes it is bound to the loader top and clocked by its system clock.
`timescale 1ns/1ps
module ascl_properties (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host request and shared done level
  input wire reloadRequestN,
  input wire loadCompleteIn,
  // Open-drain enables
  input wire configStatusNOe,
  input wire loadCompleteOe,
  input wire initDoneOe,
  // Flash link
  input wire serialLinkClock,
  input wire flashSelectOutN,
  input wire flashCommandOut,
  // Chain and user I/O
  input wire chainEnableOutN,
  input wire userIoFloat,
  input wire userIoPullupEn,
  input wire userMode,
  // Byte stream
  input wire [7:0] configByte,
  input wire configByteValid,
  input wire configByteReady
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset itself must force the busy lines, so this one is never disabled
  por_lines_a: assert property (disable iff (1'b0) !rst_n |=> configStatusNOe && loadCompleteOe)
    else $error("status or done not pulled during reset");
  float_until_user_a: assert property (!userMode |-> userIoFloat && userIoPullupEn)
    else $error("user pins not floated before user mode");
  user_io_a: assert property (userMode |-> !userIoFloat && !userIoPullupEn && !initDoneOe)
    else $error("user mode with pins floated or init-done held");
  link_idle_a: assert property (flashSelectOutN |-> !serialLinkClock)
    else $error("link clock runs while flash deselected");
  link_half_a: assert property ($rose(serialLinkClock) |=> serialLinkClock [*2])
    else $error("link clock high phase too short");
  cmd_fall_a: assert property (!flashSelectOutN && $past(!flashSelectOutN) && $changed(flashCommandOut)
    |-> $fell(serialLinkClock))
    else $error("command bit moved off the falling link edge");
  done_release_a: assert property ($fell(loadCompleteOe)
    |-> !chainEnableOutN && $past(!flashSelectOutN))
    else $error("done released before own data");
  status_select_a: assert property (configStatusNOe && $past(configStatusNOe) |-> flashSelectOutN)
    else $error("flash selected while status pulled low");
  reload_float_a: assert property (userMode && !reloadRequestN
    |-> ##[1:4] (configStatusNOe && loadCompleteOe && userIoFloat))
    else $error("reload request not honoured");
  init_after_done_a: assert property ($rose(userMode) |-> $past(loadCompleteIn, 100))
    else $error("user mode without done line high long enough");
  // Refused bytes must wait unchanged at the output
  byte_hold_a: assert property (configByteValid && !configByteReady
    |=> configByteValid && $stable(configByte))
    else $error("byte dropped while not accepted");
endmodule // ascl_properties

bind ascl_loader ascl_properties i_props (.clk(clk), .rst_n(rst_n), .reloadRequestN(reloadRequestN),
  .loadCompleteIn(loadCompleteIn), .configStatusNOe(configStatusNOe), .loadCompleteOe(loadCompleteOe),
  .initDoneOe(initDoneOe), .serialLinkClock(serialLinkClock), .flashSelectOutN(flashSelectOutN),
  .flashCommandOut(flashCommandOut), .chainEnableOutN(chainEnableOutN), .userIoFloat(userIoFloat),
  .userIoPullupEn(userIoPullupEn), .userMode(userMode), .configByte(configByte),
  .configByteValid(configByteValid), .configByteReady(configByteReady));

// [ascl_flash_model.sv]
// Behavioural serial flash: takes a 32-bit command, then streams one frame repeatedly.
// Assumes the loader drives link clock and select; data line has a pull-up when released.
`timescale 1ns/1ps
module ascl_flash_model (
  // Link from the loader
  input wire serialLinkClock,
  input wire flashSelectOutN,
  input wire flashCommandOut,
  // Content and observation
  input wire [15:0] frame,
  output logic serialDataIn = 1'b1,
  output logic [31:0] cmdWord
);
  int rises = 0;

  // Command captured on rising edges, count restarts on every deselect
  always @(posedge serialLinkClock or posedge flashSelectOutN)
    if (flashSelectOutN)
      rises <= 0;
    else
    begin
      if (rises < 32)
        cmdWord <= {cmdWord[30:0], flashCommandOut};
      rises <= rises + 1;
    end

  // Data driven on falling edges after the command; released line floats high
  always @(negedge serialLinkClock or posedge flashSelectOutN)
    if (flashSelectOutN || rises < 32)
      serialDataIn <= 1'b1;
    else
      serialDataIn <= frame[15 - ((rises - 32) % 16)];
endmodule // ascl_flash_model

// [testbench.sv]
// Self-checking bench for the loader with flash model, shared lines and byte queue.
// Assumes the loader, its checker and the flash model are compiled first.
`timescale 1ns/1ps
module testbench;
  // Stimulus
  logic clk = 1'b0, rst_n = 1'b0, reloadRequestN = 1'b1, autoRestartEn = 1'b0, configByteReady = 1'b0;
  logic userStartupClockEn = 1'b0, userStartupClock = 1'b0, hostPull = 1'b0, doneHold = 1'b1;
  logic stall = 1'b1, discard = 1'b0;
  logic [1:0] schemeSelect = 2'h1;
  logic [15:0] frame;
  logic [31:0] rnd = 32'h8E14, cmdWord;
  // Observed
  logic configStatusNOe, loadCompleteOe, initDoneOe, serialLinkClock, flashSelectOutN, flashCommandOut;
  logic serialDataIn, chainEnableOutN, userIoFloat, userIoPullupEn, userMode, configByteValid;
  logic [7:0] configByte;
  logic [7:0] expQ[$];
  int miscompares = 0, checks = 0, n;

  initial forever #5 clk = ~clk;
  // Free-running user start-up clock, unrelated to clk
  initial forever #62.5 userStartupClock = ~userStartupClock;

  // Shared open-drain lines: low if any party pulls
  ascl_loader #(.POR_CYCLES(20), .OWN_BITS(32), .TOTAL_BITS(64)) i_dut (.clk(clk), .rst_n(rst_n),
    .schemeSelect(schemeSelect), .chainEnableInN(1'b0), .reloadRequestN(reloadRequestN),
    .autoRestartEn(autoRestartEn), .userStartupClockEn(userStartupClockEn), .userStartupClock(userStartupClock),
    .configStatusNIn(~configStatusNOe & ~hostPull), .configStatusNOut(), .configStatusNOe(configStatusNOe),
    .loadCompleteIn(~loadCompleteOe & ~doneHold), .loadCompleteOut(), .loadCompleteOe(loadCompleteOe),
    .initDoneOut(), .initDoneOe(initDoneOe), .serialLinkClock(serialLinkClock), .flashSelectOutN(flashSelectOutN),
    .flashCommandOut(flashCommandOut), .serialDataIn(serialDataIn), .chainEnableOutN(chainEnableOutN),
    .userIoFloat(userIoFloat), .userIoPullupEn(userIoPullupEn), .userMode(userMode), .configByte(configByte),
    .configByteValid(configByteValid), .configByteReady(configByteReady));
  ascl_flash_model i_flash (.serialLinkClock(serialLinkClock), .flashSelectOutN(flashSelectOutN),
    .flashCommandOut(flashCommandOut), .frame(frame), .serialDataIn(serialDataIn), .cmdWord(cmdWord));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Bounded wait; running out counts as a mismatch
  task automatic waitVal(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim)
    begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= lim)
      check(1'b0, 1'b1);
  endtask

  // Random frame, first bit enables init-done; parity even unless an error is wanted
  task automatic setFrame(input logic bad);
    logic [15:0] f;
    f = {1'b1, rnd[14:1], 1'b0};
    f[0] = (^f) ^ bad;
    frame <= f;
    if (!bad)
      repeat (2)
      begin
        expQ.push_back(f[15:8]);
        expQ.push_back(f[7:0]);
      end
  endtask

  // Host reload pulse of 40 us
  task automatic reload;
    reloadRequestN <= 1'b0;
    repeat (4) @(posedge clk);
    check(configStatusNOe & loadCompleteOe & userIoFloat, 1'b1);
    repeat (3996) @(posedge clk);
    reloadRequestN <= 1'b1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Random consumer stalls, held off entirely while stall is set
  always @(posedge clk)
  begin
    rnd <= lfsr(rnd);
    configByteReady <= !stall && rnd[3];
  end

  // Every accepted byte is matched against the oldest note, except while discard is set
  always @(posedge clk)
    if (rst_n && configByteValid === 1'b1 && configByteReady && !discard)
      check(configByte, expQ.size() ? expQ.pop_front() : 8'hXX);

  // Main sequence
  initial
  begin
    setFrame(1'b0);
    repeat (20) @(posedge clk);
    check({configStatusNOe, loadCompleteOe, userIoFloat, userIoPullupEn, flashSelectOutN}, 5'h1F);
    rst_n <= 1'b1;
    repeat (100) @(posedge clk);
    check(flashSelectOutN, 1'b1);
    schemeSelect <= 2'h0;
    waitVal(chainEnableOutN, 1'b0, 2000, n);
    repeat (4) @(posedge clk);
    check({configByteValid, loadCompleteOe, initDoneOe}, 3'h5);
    stall <= 1'b0;
    repeat (400) @(posedge clk);
    check(userMode, 1'b0);
    doneHold <= 1'b0;
    waitVal(userMode, 1'b1, 3000, n);
    check(n >= 1350 && n <= 1380, 1'b1);
    check(cmdWord, 32'h03000000);
    $display("test load done");
    // User clock paces init; a held status line delays the start
    userStartupClockEn <= 1'b1;
    setFrame(1'b0);
    reload();
    hostPull <= 1'b1;
    repeat (200) @(posedge clk);
    check(flashSelectOutN, 1'b1);
    hostPull <= 1'b0;
    waitVal(flashSelectOutN, 1'b0, 100, n);
    waitVal(loadCompleteOe, 1'b0, 2000, n);
    // Time the user clock count from the end of the stream, not from own done
    waitVal(flashSelectOutN, 1'b1, 400, n);
    waitVal(userMode, 1'b1, 3000, n);
    check(n >= 1685 && n <= 1725, 1'b1);
    $display("test user clock done");
    // Frame error with auto restart
    autoRestartEn <= 1'b1;
    userStartupClockEn <= 1'b0;
    discard <= 1'b1;
    setFrame(1'b1);
    reload();
    waitVal(flashSelectOutN, 1'b0, 100, n);
    waitVal(configStatusNOe, 1'b1, 2000, n);
    check({loadCompleteOe, chainEnableOutN}, 2'h3);
    repeat (2900) @(posedge clk);
    check(configStatusNOe, 1'b1);
    discard <= 1'b0;
    setFrame(1'b0);
    waitVal(configStatusNOe, 1'b0, 200, n);
    check(n >= 90 && n <= 110, 1'b1);
    waitVal(userMode, 1'b1, 4000, n);
    $display("test auto restart done");
    // Chain partner pulls status mid-load, no auto restart
    autoRestartEn <= 1'b0;
    discard <= 1'b1;
    reload();
    waitVal(flashSelectOutN, 1'b0, 100, n);
    repeat (50) @(posedge clk);
    hostPull <= 1'b1;
    repeat (3) @(posedge clk);
    hostPull <= 1'b0;
    repeat (4000) @(posedge clk);
    check({configStatusNOe, flashSelectOutN}, 2'h3);
    discard <= 1'b0;
    setFrame(1'b0);
    reload();
    waitVal(userMode, 1'b1, 4000, n);
    check(userIoPullupEn, 1'b0);
    $display("test host restart done");
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // testbench
